// File: hw/pio_defs.vh
/*
 Timing and field constants for the PIO host controller.
 Assumes a 50 MHz system clock; times in ns are converted to cycles.
*/
`ifndef PIO_DEFS_VH
`define PIO_DEFS_VH
`define PIO_CLK_NS 20
// Cycle time t0 per mode, ns
`define PIO_T0_M0 600
`define PIO_T0_M1 383
`define PIO_T0_M2 240
`define PIO_T0_M3 180
`define PIO_T0_M4 120
// Address setup t1 per mode, ns
`define PIO_T1_M0 70
`define PIO_T1_M1 50
`define PIO_T1_M2 30
`define PIO_T1_M3 30
`define PIO_T1_M4 25
// Strobe width t2 per mode, ns (16-bit); 8-bit mode 4 is also 70
`define PIO_T2_M0 165
`define PIO_T2_M1 125
`define PIO_T2_M2 100
`define PIO_T2_M3 80
`define PIO_T2_M4 70
// Recovery t2i per mode, ns (0 where none is given)
`define PIO_T2I_M0 0
`define PIO_T2I_M1 0
`define PIO_T2I_M2 0
`define PIO_T2I_M3 70
`define PIO_T2I_M4 25
// Address hold t9 per mode, ns
`define PIO_T9_M0 20
`define PIO_T9_M1 15
`define PIO_T9_M2 10
`define PIO_T9_M3 10
`define PIO_T9_M4 10
// Read data tri-state after strobe negation, ns
`define PIO_T6Z 30
// Round a least time up to whole cycles, never below one
`define PIO_CYC(ns) (((ns) + `PIO_CLK_NS - 1) / `PIO_CLK_NS < 1 ? 1 : \
   ((ns) + `PIO_CLK_NS - 1) / `PIO_CLK_NS)
// Command word layout
`define PIO_CMD_WRITE 0
`define PIO_CMD_DATA 1
`define PIO_CMD_CS_LO 2
`define PIO_CMD_CS_HI 3
`define PIO_CMD_DA_LO 4
`define PIO_CMD_DA_HI 6
`define PIO_CMD_WD_LO 7
`define PIO_CMD_WD_HI 22
`define PIO_CMD_W 23
`define PIO_MODE_W 3
`define PIO_CNT_W 8
`endif

// File: hw/pio_fifo.v
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module pio_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk,
   input wire arst_n,
   input wire [WIDTH-1:0] in_data,
   input wire in_valid,
   output wire in_ready,
   output wire [WIDTH-1:0] out_data,
   output wire out_valid,
   input wire out_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wr_ptr;
   reg [AW-1:0] rd_ptr;
   reg [AW:0] count;
   wire push;
   wire pop;
   assign in_ready = (count != DEPTH[AW:0]);
   assign out_valid = (count != {(AW+1){1'b0}});
   assign out_data = mem[rd_ptr];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   always @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr <= {AW{1'b0}};
         rd_ptr <= {AW{1'b0}};
         count <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
               rd_ptr + 1'b1;
         end
         if (push && !pop) begin
            count <= count + 1'b1;
         end else if (pop && !push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule

// File: hw/pio_host.v
/*
 Host controller driving PIO register and data cycles to a card.
 Assumes card pins are synchronous to clk; the card inserts no waits.
*/
//
// Operation
// - Host releases all data lines while the card drives them.
// - Cycle meets active, recovery and total minimums, lengthening recovery.
// - 16-bit data strobe active at least 165 ns mode 0 to 70 mode 4.
// - 8-bit register strobe active at least 70 ns at fastest mode.
// - Register transfers move one byte on the low eight lines.
// - Data transfers move a full word on all sixteen lines.
// - Register chosen by two chip selects and three address lines.
`timescale 1ns/1ps
`include "pio_defs.vh"
module pio_host #(
   parameter FIFO_DEPTH = 16,
   parameter FIFO_AW = 4
) (
   input wire clk,
   input wire arst_n,
   input wire [`PIO_MODE_W-1:0] pio_mode,
   input wire [15:0] min_cycle_ns,
   input wire [`PIO_CMD_W-1:0] cmd,
   input wire cmd_valid,
   output reg cmd_ready,
   output reg [15:0] rd_data,
   output reg rd_valid,
   input wire rd_ready,
   output reg busy,
   output reg cs0_n,
   output reg cs1_n,
   output reg [2:0] da,
   output reg iord_n,
   output reg iowr_n,
   output reg [15:0] dd_out,
   output reg dd_oe,
   input wire [15:0] dd_in
);
   localparam ST_IDLE = 3'h0;
   localparam ST_SETUP = 3'h1;
   localparam ST_ACTIVE = 3'h2;
   localparam ST_HOLD = 3'h3;
   localparam ST_RECOV = 3'h4;
   localparam CW = `PIO_CNT_W;

   ////////////////////////////////////////////////////////////////////////
   // Per-mode cycle counts
   reg [31:0] c_t0;
   reg [31:0] c_t1;
   reg [31:0] c_t2;
   reg [31:0] c_t2i;
   reg [31:0] c_t9;
   reg [31:0] w_rep;
   reg [CW-1:0] c_rep;
   reg [CW-1:0] c_need;
   always @* begin
      case (pio_mode)
         3'h0: begin
            c_t0 = `PIO_CYC(`PIO_T0_M0);
            c_t1 = `PIO_CYC(`PIO_T1_M0);
            c_t2 = `PIO_CYC(`PIO_T2_M0);
            c_t2i = `PIO_CYC(`PIO_T2I_M0);
            c_t9 = `PIO_CYC(`PIO_T9_M0);
         end
         3'h1: begin
            c_t0 = `PIO_CYC(`PIO_T0_M1);
            c_t1 = `PIO_CYC(`PIO_T1_M1);
            c_t2 = `PIO_CYC(`PIO_T2_M1);
            c_t2i = `PIO_CYC(`PIO_T2I_M1);
            c_t9 = `PIO_CYC(`PIO_T9_M1);
         end
         3'h2: begin
            c_t0 = `PIO_CYC(`PIO_T0_M2);
            c_t1 = `PIO_CYC(`PIO_T1_M2);
            c_t2 = `PIO_CYC(`PIO_T2_M2);
            c_t2i = `PIO_CYC(`PIO_T2I_M2);
            c_t9 = `PIO_CYC(`PIO_T9_M2);
         end
         3'h3: begin
            c_t0 = `PIO_CYC(`PIO_T0_M3);
            c_t1 = `PIO_CYC(`PIO_T1_M3);
            c_t2 = `PIO_CYC(`PIO_T2_M3);
            c_t2i = `PIO_CYC(`PIO_T2I_M3);
            c_t9 = `PIO_CYC(`PIO_T9_M3);
         end
         default: begin
            c_t0 = `PIO_CYC(`PIO_T0_M4);
            c_t1 = `PIO_CYC(`PIO_T1_M4);
            c_t2 = `PIO_CYC(`PIO_T2_M4);
            c_t2i = `PIO_CYC(`PIO_T2I_M4);
            c_t9 = `PIO_CYC(`PIO_T9_M4);
         end
      endcase
      // Reported minimum only lengthens, never shortens, the cycle
      w_rep = (min_cycle_ns + `PIO_CLK_NS - 1) / `PIO_CLK_NS;
      c_rep = (w_rep > 32'h000000ff) ? {CW{1'b1}} :
         w_rep[CW-1:0];
      c_need = (pio_mode >= 3'h3 && c_rep > c_t0[CW-1:0]) ? c_rep :
         c_t0[CW-1:0];
   end

   ////////////////////////////////////////////////////////////////////////
   // Read result FIFO
   wire fifo_in_ready;
   wire [15:0] fifo_out_data;
   wire fifo_out_valid;
   reg fifo_push;
   reg [15:0] fifo_wdata;
   wire fifo_pop;
   assign fifo_pop = fifo_out_valid & (~rd_valid | rd_ready);
   pio_fifo #(
      .WIDTH(16),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .in_data(fifo_wdata),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .out_data(fifo_out_data),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop)
   );
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_valid <= 1'b0;
         rd_data <= 16'h0000;
      end else if (fifo_pop) begin
         rd_valid <= 1'b1;
         rd_data <= fifo_out_data;
      end else if (rd_ready) begin
         rd_valid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Strobe sequencer
   reg [2:0] state;
   reg [CW-1:0] cnt;
   reg [CW-1:0] total;
   reg op_wr;
   reg op_data;
   wire [CW-1:0] used;
   wire take;
   assign used = total + cnt;
   // Reads wait for FIFO room, so back-pressure stalls the bus
   assign take = cmd_valid & cmd_ready &
      (cmd[`PIO_CMD_WRITE] | fifo_in_ready);
   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         cnt <= 8'h00;
         total <= 8'h00;
         op_wr <= 1'b0;
         op_data <= 1'b0;
         cmd_ready <= 1'b0;
         busy <= 1'b0;
         cs0_n <= 1'b1;
         cs1_n <= 1'b1;
         da <= 3'h0;
         iord_n <= 1'b1;
         iowr_n <= 1'b1;
         dd_out <= 16'h0000;
         dd_oe <= 1'b0;
         fifo_push <= 1'b0;
         fifo_wdata <= 16'h0000;
      end else begin
         fifo_push <= 1'b0;
         cnt <= cnt + 1'b1;
         case (state)
            ST_IDLE: begin
               cmd_ready <= 1'b1;
               busy <= 1'b0;
               if (take) begin
                  cmd_ready <= 1'b0;
                  busy <= 1'b1;
                  op_wr <= cmd[`PIO_CMD_WRITE];
                  op_data <= cmd[`PIO_CMD_DATA];
                  cs0_n <= cmd[`PIO_CMD_CS_LO];
                  cs1_n <= cmd[`PIO_CMD_CS_HI];
                  da <= cmd[`PIO_CMD_DA_HI:`PIO_CMD_DA_LO];
                  // Byte on low lines for registers, full word for data
                  dd_out <= cmd[`PIO_CMD_DATA] ?
                     cmd[`PIO_CMD_WD_HI:`PIO_CMD_WD_LO] :
                     {8'h00, cmd[`PIO_CMD_WD_LO+7:`PIO_CMD_WD_LO]};
                  dd_oe <= cmd[`PIO_CMD_WRITE];
                  cnt <= 8'h01;
                  total <= 8'h00;
                  state <= ST_SETUP;
               end
            end
            ST_SETUP: begin
               if (cnt >= c_t1[CW-1:0]) begin
                  iord_n <= op_wr;
                  iowr_n <= ~op_wr;
                  total <= used;
                  cnt <= 8'h01;
                  state <= ST_ACTIVE;
               end
            end
            ST_ACTIVE: begin
               // Fixed timing: no wait or ready sampled
               if (cnt >= c_t2[CW-1:0]) begin
                  iord_n <= 1'b1;
                  iowr_n <= 1'b1;
                  if (!op_wr) begin
                     fifo_push <= 1'b1;
                     fifo_wdata <= op_data ? dd_in :
                        {8'h00, dd_in[7:0]};
                  end
                  total <= used;
                  cnt <= 8'h01;
                  state <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               if (cnt >= c_t9[CW-1:0]) begin
                  cs0_n <= 1'b1;
                  cs1_n <= 1'b1;
                  dd_oe <= 1'b0;
                  total <= used;
                  cnt <= 8'h01;
                  state <= ST_RECOV;
               end
            end
            ST_RECOV: begin
               // Recovery stretched until total reaches cycle minimum
               if (used >= c_need &&
                  total - c_t2[CW-1:0] + cnt >= c_t2i[CW-1:0]) begin
                  cmd_ready <= 1'b1;
                  busy <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// File: test/pio_card_model.sv
/* Behavioural card on the far side of pio_host.
   Assumes a single host on the pins; the card has no clock. */
`timescale 1ns/1ps
module pio_card_model #(
   parameter int WORD68_NS = 120
) (
   input wire cs0_n,
   input wire cs1_n,
   input wire [2:0] da,
   input wire iord_n,
   input wire iowr_n,
   input wire [15:0] dd_out,
   input wire dd_oe,
   output logic [15:0] dd_in
);
// No wait or ready output at all
logic [15:0] mem [0:15];
logic [15:0] last;
logic ack_n;
logic is16_n;
wire [3:0] a = {cs0_n, da};
wire wide = !cs0_n && da == 3'h0;
initial dd_in = 16'h0000;
initial ack_n = 1'b1;
initial is16_n = 1'b1;
// Input acknowledge follows the read strobe
always @(iord_n) #20 ack_n = iord_n;
// 16-bit port indication from the decoded address
always @(cs0_n or da) #30 is16_n = !wide;
// Stores on release, however the cycle was split
always @(posedge iowr_n)
   if (dd_oe && !(cs0_n && cs1_n))
      mem[a] <= wide ? dd_out : {8'h00, dd_out[7:0]};
always @(negedge iord_n)
   #5 dd_in = wide ? mem[a] : {8'h5a, mem[a][7:0]};
// Lets go 25 ns after release, then shows the inverse
always @(posedge iord_n) begin
   last = dd_in;
   #25 dd_in = ~last;
end
endmodule

// File: test/pio_host_checker.sv
/* Pin timing checker for pio_host.
   Assumes a 20 ns clock and a mode held through each cycle. */
`timescale 1ns/1ps
module pio_host_checker (
   input wire clk,
   input wire arst_n,
   input wire [2:0] pio_mode,
   input wire [15:0] min_cycle_ns,
   input wire [22:0] cmd,
   input wire cmd_valid,
   input wire cmd_ready,
   input wire busy,
   input wire cs0_n,
   input wire cs1_n,
   input wire [2:0] da,
   input wire iord_n,
   input wire iowr_n,
   input wire [15:0] dd_out,
   input wire dd_oe
);
localparam int T0C[5] = '{30, 20, 12, 9, 6};
localparam int T1C[5] = '{4, 3, 2, 2, 2};
localparam int T2C[5] = '{9, 7, 5, 4, 4};
wire st = iord_n & iowr_n;
wire [4:0] ad = {cs0_n, cs1_n, da};
wire [2:0] m = (pio_mode > 3'h4) ? 3'h4 : pio_mode;
wire [15:0] w = (min_cycle_ns + 16'h0013) / 16'h0014;
logic st_q;
logic [4:0] ad_q;
logic [7:0] act, tot, aset;
int need;
always_comb need = (m > 3'h2 && int'(w) > T0C[m]) ? int'(w) : T0C[m];
////////////////////////////////////////
always_ff @(posedge clk or negedge arst_n) begin
   if (!arst_n) begin
      st_q <= 1'b1;
      ad_q <= 5'h1f;
      act <= 8'h00;
      tot <= 8'hff;
      aset <= 8'h00;
   end else begin
      st_q <= st;
      ad_q <= ad;
      act <= st ? 8'h00 : act + 8'h01;
      tot <= (st_q && !st) ? 8'h01 : tot + {7'h00, tot != 8'hff};
      aset <= (ad != ad_q) ? 8'h01 : aset + {7'h00, aset != 8'hff};
   end
end
////////////////////////////////////////
default clocking @(posedge clk); endclocking
default disable iff (!arst_n);
sequence s_take_wr;
   cmd_valid && cmd_ready && cmd[0];
endsequence
sequence s_wr_pulse;
   ##[1:12] !iowr_n ##[1:12] iowr_n;
endsequence
a_strobe_excl: assert property (iord_n || iowr_n)
   else $error("both strobes low");
a_read_undriven: assert property (!iord_n |-> !dd_oe)
   else $error("data driven during read");
a_active_width: assert property ($rose(st) |-> act >= T2C[m])
   else $error("strobe too short");
a_total_cycle: assert property ($fell(st) |-> tot >= need)
   else $error("cycle too short");
a_addr_setup: assert property ($fell(st) |-> aset >= T1C[m])
   else $error("address setup too short");
a_addr_stable: assert property (!st && !$past(st) |-> $stable(ad))
   else $error("address moved under strobe");
a_write_drive: assert property (!iowr_n |-> dd_oe && $stable(dd_out))
   else $error("write data not held");
a_take_write: assert property (s_take_wr |-> s_wr_pulse)
   else $error("write strobe missing");
a_cycle_done: assert property ($rose(busy) |-> ##[1:80] cmd_ready)
   else $error("cycle did not end");
endmodule
bind pio_host pio_host_checker u_pio_host_checker (
   .clk(clk), .arst_n(arst_n), .pio_mode(pio_mode),
   .min_cycle_ns(min_cycle_ns), .cmd(cmd), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .busy(busy), .cs0_n(cs0_n), .cs1_n(cs1_n),
   .da(da), .iord_n(iord_n), .iowr_n(iowr_n), .dd_out(dd_out),
   .dd_oe(dd_oe));

// File: test/test_pio_io_transfer_timing.sv
/* Self-checking bench for pio_host with a behavioural card.
   Assumes a 50 MHz clock and a 16-word read FIFO. */
`timescale 1ns/1ps
module test_pio_io_transfer_timing;
logic clk = 1'b0;
logic arst_n = 1'b0;
logic cmd_valid = 1'b0;
logic rd_ready = 1'b1;
logic [2:0] pio_mode = 3'h4;
logic [15:0] min_cycle_ns = 16'h0000;
logic [22:0] cmd = 23'h000000;
wire cmd_ready, rd_valid, busy, cs0_n, cs1_n, iord_n, iowr_n, dd_oe;
wire [2:0] da;
wire [15:0] rd_data, dd_out, dd_in;
int bad_count = 0;
int comparisons = 0;
logic [15:0] got [$];
always #10 clk = ~clk;
pio_host u_pio_host (
   .clk(clk), .arst_n(arst_n), .pio_mode(pio_mode),
   .min_cycle_ns(min_cycle_ns), .cmd(cmd), .cmd_valid(cmd_valid),
   .cmd_ready(cmd_ready), .rd_data(rd_data), .rd_valid(rd_valid),
   .rd_ready(rd_ready), .busy(busy), .cs0_n(cs0_n), .cs1_n(cs1_n),
   .da(da), .iord_n(iord_n), .iowr_n(iowr_n), .dd_out(dd_out),
   .dd_oe(dd_oe), .dd_in(dd_in));
pio_card_model #(.WORD68_NS(200)) u_pio_card_model (
   .cs0_n(cs0_n), .cs1_n(cs1_n), .da(da), .iord_n(iord_n),
   .iowr_n(iowr_n), .dd_out(dd_out), .dd_oe(dd_oe), .dd_in(dd_in));
always @(posedge clk)
   if (rd_valid === 1'b1 && rd_ready === 1'b1)
      got.push_back(rd_data);
////////////////////////////////////////
function automatic bit seen(input bit ok);
   comparisons++;
   return ok;
endfunction
task automatic miss(input string s);
   bad_count++;
   $display("MISMATCH %0t %s", $time, s);
endtask
function automatic logic [22:0] mk(input bit wr, input logic [3:0] a,
   input logic [15:0] v);
   return {v, a[2:0], ~a[3], a[3], a == 4'h0, wr};
endfunction
function automatic logic [15:0] val(input int i);
   return 16'h1357 + 16'(i) * 16'h0f31;
endfunction
task automatic idle;
   int n;
   n = 0;
   do begin
      @(posedge clk);
      n++;
   end while (!(cmd_ready === 1'b1 && busy === 1'b0) && n < 200);
endtask
task automatic issue(input logic [22:0] c, output bit ok);
   int n;
   ok = 1'b0;
   idle();
   cmd <= c;
   cmd_valid <= 1'b1;
   for (n = 0; n < 40 && !ok; n++) begin
      @(posedge clk);
      ok = busy === 1'b1;
   end
   cmd_valid <= 1'b0;
endtask
task automatic drain(input int k);
   int n;
   for (n = 0; n < 400 && got.size() < k; n++)
      @(posedge clk);
endtask
////////////////////////////////////////
task automatic t_modes;
   bit ok;
   int m;
   for (m = 0; m < 5; m++) begin
      idle();
      pio_mode <= 3'(m);
      issue(mk(1'b1, 4'h0, val(m + 20)), ok);
      issue(mk(1'b0, 4'h0, 16'h0000), ok);
      drain(1);
      if (!seen(got.size() == 1 && got[0] === val(m + 20)))
         miss("data word");
      got.delete();
   end
endtask
task automatic t_fifo;
   bit ok;
   int i, n;
   for (i = 0; i < 16; i++)
      issue(mk(1'b1, 4'(i), val(i)), ok);
   rd_ready <= 1'b0;
   n = 0;
   ok = 1'b1;
   while (ok && n < 20) begin
      issue(mk(1'b0, 4'(n), 16'h0000), ok);
      n += int'(ok);
   end
   if (!seen(n >= 16 && n < 20))
      miss("full FIFO took a read");
   @(posedge clk);
   rd_ready <= 1'b1;
   drain(n);
   for (i = 0; i < n; i++)
      if (!seen(got[i] === (i % 16 == 0 ? val(0) : val(i % 16) & 16'h00ff)))
         miss("read data");
   got.delete();
endtask
task automatic t_word68;
   bit ok;
   int n;
   idle();
   min_cycle_ns <= 16'(u_pio_card_model.WORD68_NS);
   issue(mk(1'b1, 4'h9, 16'h00c3), ok);
   for (n = 0; n < 100 && cmd_ready !== 1'b1; n++)
      @(posedge clk);
   if (!seen(ok && n >= 10))
      miss("cycle shorter than reported minimum");
endtask
////////////////////////////////////////
task automatic tally_and_finish;
   if (bad_count == 0 && comparisons > 0)
      $display("Simulation passed");
   else
      $display("Simulation failed");
   $finish;
endtask
initial begin
   repeat (10) @(posedge clk);
   arst_n <= 1'b1;
   t_modes();
   t_fifo();
   t_word68();
   tally_and_finish();
end
initial begin
   repeat (20000) @(posedge clk);
   miss("watchdog expired");
   tally_and_finish();
end
endmodule
